/* lvrm_top.sv */
// lvrm_top: digital side of the supply monitor: reset filter, flag filter, registers.
// assumes comparator and crystal inputs already synchronous to clk; one AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module lvrm_top
    import lvrm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire lvrm_cmp_t supplyCmp,
    input wire logic crystalClock,
    input wire logic waitMode,
    input wire logic stopMode,
    output logic chipReset,
    output logic resetPinOut,
    output logic resetPinOeN,
    output logic irq
);
    // bus state
    logic wrPend_r, wrPend_nxt;
    logic [ADDR_W-1:0] wrAddr_r, wrAddr_nxt;
    logic [31:0] rdData_r, rdData_nxt;
    lvrm_cfg_t cfg_r, cfg_nxt;
    logic [EVT_W-1:0] events_r, events_nxt;
    logic [EVT_W-1:0] mask_r, mask_nxt;

    // monitor state
    lvrm_state_t state_r, state_nxt;
    logic [3:0] lowCnt_r, lowCnt_nxt;
    logic [5:0] flagCnt_r, flagCnt_nxt;
    logic flag_r, flag_nxt;
    logic xtalPrev_r, xtalPrev_nxt;

    logic addrPhase;
    logic monActive;
    logic resetArmed;
    logic stopBypass;
    logic filterTrip;
    logic xtalEdge;
    logic belowFall;
    logic aboveRise;
    logic [EVT_W-1:0] evtSet;
    logic [EVT_W-1:0] evtClr;

    assign belowFall = supplyCmp.supplyBelowFall;
    assign aboveRise = supplyCmp.supplyAboveRise;
    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

    // wait mode leaves the monitor running; of the two modes only stop without stop monitoring parks it
    assign monActive = cfg_r.monitorPowerEnable && !(stopMode && !cfg_r.stopModeMonitorEnable);
    assign resetArmed = monActive && cfg_r.undervoltageResetEnable;
    assign stopBypass = resetArmed && stopMode && belowFall;
    assign filterTrip = resetArmed && belowFall && (lowCnt_r == LOW_LAST);
    assign xtalEdge = crystalClock && !xtalPrev_r;

    assign evtSet[EVT_RESET_BIT] = (state_r == ST_WATCH) && (filterTrip || stopBypass);
    assign evtSet[EVT_FLAG_BIT] = flag_nxt && !flag_r;

    // reset filter and reset state
    always_comb begin
        state_nxt = state_r;
        lowCnt_nxt = lowCnt_r;
        if (!monActive || !belowFall) begin
            lowCnt_nxt = '0;
        end else if (lowCnt_r != LOW_LAST) begin
            lowCnt_nxt = lowCnt_r + 4'h1;
        end
        unique case (state_r)
            ST_WATCH: begin
                if (filterTrip || stopBypass) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (aboveRise) begin
                    state_nxt = ST_WATCH;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_WATCH;
            lowCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            lowCnt_r <= lowCnt_nxt;
        end
    end

    // flag filter on crystal edges; counter freezes once the set point is reached
    always_comb begin
        xtalPrev_nxt = crystalClock;
        flagCnt_nxt = flagCnt_r;
        flag_nxt = flag_r;
        if (state_r == ST_HOLD) begin
            flagCnt_nxt = '0;
            flag_nxt = 1'b0;
        end else if (aboveRise) begin
            flagCnt_nxt = '0;
            flag_nxt = 1'b0;
        end else if (!monActive) begin
            flagCnt_nxt = '0;
        end else if (belowFall) begin
            if (xtalEdge && flagCnt_r != FLAG_SET_CYCLES) begin
                flagCnt_nxt = flagCnt_r + 6'h01;
            end
            if (flagCnt_r == FLAG_SET_CYCLES) begin
                flag_nxt = 1'b1;
            end
        end else begin
            flagCnt_nxt = '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flagCnt_r <= '0;
            flag_r <= 1'b0;
            xtalPrev_r <= 1'b0;
        end else begin
            flagCnt_r <= flagCnt_nxt;
            flag_r <= flag_nxt;
            xtalPrev_r <= xtalPrev_nxt;
        end
    end

    // register file: zero wait states, read data captured in the address phase
    always_comb begin
        wrPend_nxt = addrPhase && hwrite;
        wrAddr_nxt = haddr[ADDR_W-1:0];
        rdData_nxt = rdData_r;
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        evtClr = '0;
        if (addrPhase && !hwrite) begin
            rdData_nxt = '0;
            unique case (haddr[ADDR_W-1:0])
                ADDR_STATUS: rdData_nxt[FLAG_BIT] = flag_r;
                ADDR_CONFIG: rdData_nxt[CFG_STOP_BIT:CFG_PWR_BIT] = cfg_r;
                ADDR_EVENTS: rdData_nxt[EVT_W-1:0] = events_r;
                ADDR_MASK: rdData_nxt[EVT_W-1:0] = mask_r;
                default: rdData_nxt = '0;
            endcase
        end
        if (wrPend_r) begin
            unique case (wrAddr_r)
                ADDR_CONFIG: cfg_nxt = hwdata[CFG_STOP_BIT:CFG_PWR_BIT];
                ADDR_EVENTS: evtClr = hwdata[EVT_W-1:0];
                ADDR_MASK: mask_nxt = hwdata[EVT_W-1:0];
                default: cfg_nxt = cfg_r;
            endcase
        end
        // a new event wins over a clear in the same cycle
        events_nxt = (events_r & ~evtClr) | evtSet;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= '0;
            rdData_r <= '0;
            cfg_r <= CFG_RESET;
            events_r <= '0;
            mask_r <= '0;
        end else begin
            wrPend_r <= wrPend_nxt;
            wrAddr_r <= wrAddr_nxt;
            rdData_r <= rdData_nxt;
            cfg_r <= cfg_nxt;
            events_r <= events_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign hrdata = rdData_r;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign chipReset = (state_r == ST_HOLD);
    assign resetPinOut = 1'b0;
    assign resetPinOeN = !(state_r == ST_HOLD);
    // unmasked events are visible through the pending bits only; no request line is raised
    assign irq = 1'b0;

    // checks
    // second count of crystal rises in the current low stretch, kept apart from the flag filter
    logic [5:0] chkLow_r, chkLow_nxt;

    always_comb begin
        chkLow_nxt = chkLow_r;
        if (!belowFall || !monActive || chipReset) begin
            chkLow_nxt = '0;
        end else if (xtalEdge && !(&chkLow_r)) begin
            chkLow_nxt = chkLow_r + 6'h01;
        end
    end

    // saturates, so a long brownout cannot wrap it back under the window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chkLow_r <= '0;
        end else begin
            chkLow_r <= chkLow_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence lowRun8;
        (resetArmed && belowFall && !stopMode)[*8];
    endsequence

    sequence lastLowCycle;
        resetArmed && belowFall && (lowCnt_r == LOW_LAST);
    endsequence

    sequence stopTrip;
        (state_r == ST_WATCH) && stopBypass;
    endsequence

    a_filter_nine: assert property (lowRun8 ##1 (resetArmed && belowFall) |=> chipReset)
        else $error("reset not raised after nine low cycles");
    a_no_early_trip: assert property (!chipReset ##1 chipReset |-> $past(stopBypass) ||
        ($past(lowCnt_r) == LOW_LAST && $past(belowFall)))
        else $error("reset raised before filter count");
    a_release_one: assert property (chipReset && aboveRise |=> !chipReset)
        else $error("reset not released after one high cycle");
    a_hold_low: assert property (chipReset && !aboveRise |=> chipReset)
        else $error("reset released while supply not above rising level");
    a_pin_follows: assert property (chipReset == !resetPinOeN && !resetPinOut)
        else $error("reset pin not driven low with reset");
    a_no_irq: assert property (!irq)
        else $error("interrupt raised");
    a_flag_high_clear: assert property (aboveRise |=> !flag_r)
        else $error("flag set above rising level");
    a_flag_mid_hold: assert property (!aboveRise && !belowFall && !chipReset |=> $stable(flag_r))
        else $error("flag changed between levels");
    a_flag_set_time: assert property ($rose(flag_r) |-> $past(flagCnt_r) >= FLAG_MIN_CYCLES &&
        $past(flagCnt_r) < FLAG_MAX_CYCLES && $past(belowFall))
        else $error("flag set at wrong crystal count");
    a_inactive_quiet: assert property (!resetArmed && !chipReset |=> !chipReset)
        else $error("reset while monitor disarmed");
    a_stop_bypass: assert property (stopTrip |=> chipReset ##0 events_r[EVT_RESET_BIT])
        else $error("stop trip did not reset at once");
    a_flag_event: assert property ($rose(flag_r) |-> events_r[EVT_FLAG_BIT])
        else $error("flag rise not recorded as event");
    a_reset_event: assert property ($rose(chipReset) |-> events_r[EVT_RESET_BIT])
        else $error("reset not recorded as event");

    // sticky status: only a written one takes a bit down
    a_event_sticky: assert property (events_r[EVT_RESET_BIT] &&
        !(wrPend_r && wrAddr_r == ADDR_EVENTS && hwdata[EVT_RESET_BIT]) |=> events_r[EVT_RESET_BIT])
        else $error("event bit lost without a clear");
    a_event_clear: assert property (wrPend_r && wrAddr_r == ADDR_EVENTS && hwdata[EVT_FLAG_BIT] &&
        !evtSet[EVT_FLAG_BIT] |=> !events_r[EVT_FLAG_BIT])
        else $error("event bit not cleared by written one");

    // wait mode must not slow the filter down
    a_wait_trip: assert property ((waitMode && !stopMode) ##0 lastLowCycle |=> chipReset)
        else $error("wait mode blocked the reset");
    a_count_restart: assert property (!belowFall |=> (lowCnt_r == '0))
        else $error("filter count kept over a high cycle");
    a_unpowered_idle: assert property (!cfg_r.monitorPowerEnable |=> (lowCnt_r == '0) && (flagCnt_r == '0))
        else $error("filters ran while unpowered");
    a_stop_parked: assert property (stopMode && !cfg_r.stopModeMonitorEnable && !chipReset |=>
        !chipReset && (lowCnt_r == '0))
        else $error("monitor active in stop without stop monitoring");
    a_polled_quiet: assert property (cfg_r.monitorPowerEnable && !cfg_r.undervoltageResetEnable &&
        !chipReset |=> !chipReset)
        else $error("reset while only polling");
    a_hold_flag_clear: assert property (chipReset |=> !flag_r)
        else $error("flag kept through reset");

    // window bounds on the independent count
    a_flag_clear_early: assert property (!flag_r && chkLow_r < FLAG_MIN_CYCLES |=> !flag_r)
        else $error("flag set too early");
    a_flag_set_late: assert property (chkLow_r > FLAG_MAX_CYCLES |-> flag_r)
        else $error("flag not set after window");
endmodule // lvrm_top
`default_nettype wire

/* lvrm_pkg.sv */
// lvrm_pkg: constants, register map and types of the low voltage reset monitor.
// assumes a single 25 MHz clock domain and a 32-bit AHB-Lite register bus.
`default_nettype none
package lvrm_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_EVENTS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    localparam int ADDR_W = 8;

    // field positions
    localparam int FLAG_BIT = 0;
    localparam int CFG_PWR_BIT = 0;
    localparam int CFG_RST_BIT = 1;
    localparam int CFG_STOP_BIT = 2;
    localparam int EVT_RESET_BIT = 0;
    localparam int EVT_FLAG_BIT = 1;
    localparam int EVT_W = 2;

    // filter counts
    localparam logic [3:0] LOW_CYCLES = 4'h9;
    localparam logic [3:0] LOW_LAST = 4'h8;
    localparam logic [5:0] FLAG_MIN_CYCLES = 6'h20;
    localparam logic [5:0] FLAG_MAX_CYCLES = 6'h28;
    localparam logic [5:0] FLAG_SET_CYCLES = 6'h24;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic stopModeMonitorEnable;
        logic undervoltageResetEnable;
        logic monitorPowerEnable;
    } lvrm_cfg_t;

    localparam lvrm_cfg_t CFG_RESET = '{stopModeMonitorEnable: 1'b0,
        undervoltageResetEnable: 1'b1, monitorPowerEnable: 1'b1};

    typedef struct packed {
        logic supplyBelowFall;
        logic supplyAboveRise;
    } lvrm_cmp_t;

    typedef enum logic [1:0] {
        ST_WATCH = 2'b01,
        ST_HOLD = 2'b10
    } lvrm_state_t;
endpackage
`default_nettype wire

/* lvrm_supply_model.sv */
// lvrm_supply_model: supply comparator, crystal source and reset pin pull-up.
// assumes level changes at clk rising edges: 0 below falling, 1 between, 2 above rising.
`timescale 1ns/1ps
`default_nettype none
module lvrm_supply_model
    import lvrm_pkg::*;
(
    input wire logic clk,
    input wire logic [1:0] level,
    input wire logic resetPinOut,
    input wire logic resetPinOeN,
    output lvrm_cmp_t supplyCmp,
    output logic crystalClock,
    output logic resetPin
);
    logic xtal = 1'b0;
    // trip levels are ordered, so both flags are never high together
    assign supplyCmp = '{supplyBelowFall: (level == 2'h0), supplyAboveRise: (level == 2'h2)};
    // half the cpu rate, kept synchronous so the design can sample it
    always @(posedge clk) xtal <= ~xtal;
    assign crystalClock = xtal;
    // open-drain pin, external pull-up
    assign resetPin = resetPinOeN ? 1'b1 : resetPinOut;
endmodule // lvrm_supply_model
`default_nettype wire

/* lvrm_top_test.sv */
// lvrm_top_test: directed bench for the supply monitor through its bus and pins.
// assumes lvrm_supply_model stands for comparator, crystal and reset pin.
`timescale 1ns/1ps
`default_nettype none
module lvrm_top_test
    import lvrm_pkg::*;
;
    logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, waitMode, stopMode, rsp;
    logic chipReset, resetPinOut, resetPinOeN, irq, crystalClock, resetPin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, level;
    logic [2:0] hsize;
    lvrm_cmp_t supplyCmp;
    int errors = 0;
    int nChecks = 0;
    int cycles = 0;
    assign hready = hreadyout;
    lvrm_top dut(.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .supplyCmp(supplyCmp), .crystalClock(crystalClock), .waitMode(waitMode),
        .stopMode(stopMode), .chipReset(chipReset), .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
        .irq(irq));
    lvrm_supply_model model(.clk(clk), .level(level), .resetPinOut(resetPinOut),
        .resetPinOeN(resetPinOeN), .supplyCmp(supplyCmp), .crystalClock(crystalClock), .resetPin(resetPin));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // run is about 340 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // called and returns at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        rsp = hresp;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, rd);
        check("hresp", {31'h0, HRESP_OKAY}, {31'h0, rsp});
    endtask
    // level sampled at n edges; pins checked after the first n-1 of them
    task automatic hold(input logic [1:0] lv, input int n, input logic expRst);
        level <= lv;
        repeat (n - 1) @(posedge clk);
        @(negedge clk);
        check("chipReset", {31'h0, expRst}, {31'h0, chipReset});
        check("resetPin", {31'h0, ~expRst}, {31'h0, resetPin});
        check("irq", 32'h0, {31'h0, irq});
        @(posedge clk);
    endtask
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        waitMode = 1'b0;
        stopMode = 1'b0;
        level = 2'h2;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdchk("config", ADDR_CONFIG, 32'h3);
        rdchk("status", ADDR_STATUS, 32'h0);
        rdchk("unmapped", 8'h10, 32'h0);
        bus(1'b1, ADDR_STATUS, 32'h1);
        rdchk("status", ADDR_STATUS, 32'h0);
        $display("test registers done");
        waitMode <= 1'b1;
        hold(2'h0, 8, 1'b0);
        hold(2'h1, 2, 1'b0);
        hold(2'h0, 9, 1'b0);
        hold(2'h0, 3, 1'b1);
        hold(2'h2, 1, 1'b1);
        hold(2'h1, 3, 1'b0);
        $display("test reset filter done");
        bus(1'b1, ADDR_CONFIG, 32'h1);
        hold(2'h0, 50, 1'b0);
        rdchk("flag", ADDR_STATUS, 32'h0);
        hold(2'h0, 40, 1'b0);
        rdchk("flag", ADDR_STATUS, 32'h1);
        hold(2'h1, 20, 1'b0);
        rdchk("flag", ADDR_STATUS, 32'h1);
        hold(2'h2, 3, 1'b0);
        rdchk("flag", ADDR_STATUS, 32'h0);
        $display("test flag done");
        rdchk("events", ADDR_EVENTS, 32'h3);
        bus(1'b1, ADDR_EVENTS, 32'h3);
        rdchk("events", ADDR_EVENTS, 32'h0);
        bus(1'b1, ADDR_MASK, 32'h3);
        rdchk("mask", ADDR_MASK, 32'h3);
        hold(2'h2, 2, 1'b0);
        $display("test events done");
        bus(1'b1, ADDR_CONFIG, 32'h2);
        hold(2'h0, 20, 1'b0);
        hold(2'h1, 2, 1'b0);
        bus(1'b1, ADDR_CONFIG, 32'h3);
        stopMode <= 1'b1;
        hold(2'h0, 20, 1'b0);
        hold(2'h1, 2, 1'b0);
        bus(1'b1, ADDR_CONFIG, 32'h7);
        hold(2'h0, 3, 1'b1);
        hold(2'h2, 3, 1'b0);
        stopMode <= 1'b0;
        $display("test power and stop done");
        bus(1'b1, ADDR_CONFIG, 32'h1);
        hold(2'h0, 90, 1'b0);
        reset <= 1'b1;
        level <= 2'h1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdchk("status", ADDR_STATUS, 32'h0);
        rdchk("config", ADDR_CONFIG, 32'h3);
        $display("test second reset done");
        complete_run();
    end
endmodule // lvrm_top_test
`default_nettype wire
